/* verilog/port2_pkg.sv */
`default_nettype none
package port2_pkg;
	// ********************************
	// widths and register map
	// ********************************
	localparam int          PORT_W       = 8;
	localparam int          ADDR_W       = 16;
	localparam logic [15:0] DIR_OFFSET   = 16'hffc1;
	localparam logic [15:0] LATCH_OFFSET = 16'hffc3;
	localparam logic [15:0] PULL_OFFSET  = 16'hffd8;
	// ********************************
	// reset values and fixed readings
	// ********************************
	localparam logic [7:0] DIR_RESET     = 8'h00;
	localparam logic [7:0] LATCH_RESET   = 8'h00;
	localparam logic [7:0] PULL_RESET    = 8'h00;
	localparam logic [7:0] DIR_READBACK  = 8'hff;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [7:0] ALL_DRIVE_N   = 8'h00;
	localparam logic [7:0] NONE_DRIVE_N  = 8'hff;
	localparam logic [7:0] ADDR_DIR      = 8'hff;
	// ********************************
	// operating modes on the mode input
	// ********************************
	localparam logic [2:0] MODE_1 = 3'h1;
	localparam logic [2:0] MODE_3 = 3'h3;
	localparam logic [2:0] MODE_5 = 3'h5;
	// ********************************
	// pin function classes, one-hot
	// ********************************
	typedef enum logic [2:0] {
		FN_ADDR  = 3'b001,
		FN_MIXED = 3'b010,
		FN_GPIO  = 3'b100
	} port_fn_t;
	// ********************************
	// pin-side bundle
	// ********************************
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
		logic [7:0] pull;
	} pin_drive_t;
endpackage
`default_nettype wire

/* verilog/addr_port.sv */
// Function
// [R01] write-only direction bit per pin
// [R02] direction clears on reset, holds in standby
// [R03] outputs keep driving during software standby
// [R04] modes 1,3: direction all ones, inaccessible
// [R05] readable writable output data latch
// [R06] output pins read back latch value
// [R07] input pins read sampled pin level
// [R08] latch clears on reset, holds in standby
// [R09] pull-up control register, bit per pin
// [R10] pull-up control clears, holds in standby
// [R11] modes 5-7: pull-up when control set, input
// [R12] modes 1,3: pull-ups always off
// [R13] pull-ups off in reset, held in standby
// [R14] modes 1,3: pins are address outputs
// [R15] mode 5: direction picks address or input
// [R16] software sets direction before address use
// [R17] modes 6,7: direction picks output or input
// [R18] address outputs carry address bits 15..8
// [R19] single-chip outputs show latch bits
//
// Design decisions made here: strobed register access and the placing of the registers.
`default_nettype none
module addr_port #(
	parameter int PORT_W = port2_pkg::PORT_W
) (
	// clock and reset
	input  wire logic                     CORE_CLK,
	input  wire logic                     RST,
	// operating state of the chip
	input  wire logic [2:0]               MODE,
	input  wire logic                     HW_STANDBY,
	input  wire logic                     SW_STANDBY,
	// upper address byte from the bus controller
	input  wire logic [PORT_W-1:0]        ADDR_HI,
	// register port
	input  wire logic [port2_pkg::ADDR_W-1:0] ADDR,
	input  wire logic [PORT_W-1:0]        WDATA,
	input  wire logic                     WR,
	input  wire logic                     RD,
	output logic      [PORT_W-1:0]        RDATA,
	// pins
	input  wire logic [PORT_W-1:0]        PIN_IN,
	output logic      [PORT_W-1:0]        PIN_OUT,
	output logic      [PORT_W-1:0]        PIN_OE_N,
	output logic      [PORT_W-1:0]        PULLUP_EN
);
	// ********************************
	// mode decode
	// ********************************
	// used by the pin logic and the bus gating
	function automatic port2_pkg::port_fn_t fn_of(input logic [2:0] m);
		if (m == port2_pkg::MODE_1 || m == port2_pkg::MODE_3) begin
			fn_of = port2_pkg::FN_ADDR;
		end else if (m == port2_pkg::MODE_5) begin
			fn_of = port2_pkg::FN_MIXED;
		end else begin
			fn_of = port2_pkg::FN_GPIO; // undefined codes act single-chip
		end
	endfunction

	port2_pkg::port_fn_t fn;
	logic                clear;
	assign fn    = fn_of(MODE);
	assign clear = RST | HW_STANDBY;

	// ********************************
	// pin input synchroniser
	// ********************************
	logic [PORT_W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [PORT_W-1:0] s1_next, s2_next, s3_next, lvl_next;

	// level moves only once the last two stages agree
	always_comb begin
		s1_next = PIN_IN;
		s2_next = s1_reg;
		s3_next = s2_reg;
		for (int i = 0; i < PORT_W; i++) begin
			lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			lvl_reg <= '0;
		end else begin
			s1_reg  <= s1_next;
			s2_reg  <= s2_next;
			s3_reg  <= s3_next;
			lvl_reg <= lvl_next;
		end
	end

	// ********************************
	// register file
	// ********************************
	logic [PORT_W-1:0] dir_reg, latch_reg, pull_reg;
	logic [PORT_W-1:0] dir_next, latch_next, pull_next;
	logic [PORT_W-1:0] dir_eff;
	logic              wr_ok;

	// address modes present a fixed all-output direction
	assign dir_eff = (fn == port2_pkg::FN_ADDR) ?
		port2_pkg::ADDR_DIR : dir_reg; // R04 R14
	// cpu is halted in software standby, so writes are dropped
	assign wr_ok = WR & ~SW_STANDBY;

	always_comb begin
		dir_next   = dir_reg;
		latch_next = latch_reg;
		pull_next  = pull_reg;
		if (wr_ok && ADDR == port2_pkg::DIR_OFFSET) begin
			if (fn != port2_pkg::FN_ADDR) begin
				dir_next = WDATA; // R01 R04
			end
		end else if (wr_ok && ADDR == port2_pkg::LATCH_OFFSET) begin
			latch_next = WDATA; // R05
		end else if (wr_ok && ADDR == port2_pkg::PULL_OFFSET) begin
			pull_next = WDATA; // R09
		end
	end

	// hardware standby clears like reset; soft standby keeps all
	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			dir_reg   <= port2_pkg::DIR_RESET;   // R02
			latch_reg <= port2_pkg::LATCH_RESET; // R08
			pull_reg  <= port2_pkg::PULL_RESET;  // R10
		end else begin
			dir_reg   <= dir_next;
			latch_reg <= latch_next;
			pull_reg  <= pull_next;
		end
	end

	// ********************************
	// read path
	// ********************************
	logic [PORT_W-1:0] rdata_reg, rdata_next;

	// port read mixes latch and pin per direction bit
	always_comb begin
		rdata_next = port2_pkg::UNMAPPED_READ;
		if (RD && ADDR == port2_pkg::DIR_OFFSET) begin
			rdata_next = port2_pkg::DIR_READBACK; // write-only
		end else if (RD && ADDR == port2_pkg::LATCH_OFFSET) begin
			rdata_next = (dir_eff & latch_reg) |
				(~dir_eff & lvl_reg); // R06 R07
		end else if (RD && ADDR == port2_pkg::PULL_OFFSET) begin
			rdata_next = pull_reg;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	assign RDATA = rdata_reg;

	// ********************************
	// pin drivers and pull-ups
	// ********************************
	port2_pkg::pin_drive_t drv_reg, drv_next;

	always_comb begin
		drv_next = drv_reg;
		if (!SW_STANDBY) begin
			drv_next.oe_n = ~dir_eff; // R15 R17
			drv_next.pull = '0;       // R12
			case (fn)
				port2_pkg::FN_ADDR: begin
					drv_next.out = ADDR_HI; // R14 R18
				end
				port2_pkg::FN_MIXED: begin
					drv_next.out  = ADDR_HI;            // R15 R18
					drv_next.pull = pull_reg & ~dir_reg; // R11
				end
				default: begin
					drv_next.out  = latch_reg;           // R19
					drv_next.pull = pull_reg & ~dir_reg; // R11
				end
			endcase
		end
	end

	// software standby freezes pins; reset and hardware standby release them, pull-ups off
	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			drv_reg.out  <= '0;
			drv_reg.oe_n <= port2_pkg::NONE_DRIVE_N;
			drv_reg.pull <= '0; // R13
		end else begin
			drv_reg <= drv_next; // R03 R13
		end
	end
	assign PIN_OUT   = drv_reg.out;
	assign PIN_OE_N  = drv_reg.oe_n;
	assign PULLUP_EN = drv_reg.pull;

	// ********************************
	// assertions
	// ********************************
	logic run;
	assign run = ~clear & ~SW_STANDBY;

	clear_regs_a: assert property (@(posedge CORE_CLK) // R02
		clear |=> dir_reg == '0 && latch_reg == '0 && pull_reg == '0
			&& PULLUP_EN == '0)
		else $error("registers not cleared");

	dir_write_a: assert property ( // R01
		@(posedge CORE_CLK) disable iff (clear)
		wr_ok && ADDR == port2_pkg::DIR_OFFSET
			&& fn != port2_pkg::FN_ADDR |=> dir_reg == $past(WDATA))
		else $error("direction write lost");

	dir_locked_a: assert property ( // R04
		@(posedge CORE_CLK) disable iff (clear)
		run && fn == port2_pkg::FN_ADDR |=> PIN_OE_N == '0)
		else $error("address mode not all outputs");

	// address modes ignore direction writes entirely
	dir_frozen_a: assert property ( // R04
		@(posedge CORE_CLK) disable iff (clear)
		fn == port2_pkg::FN_ADDR |=> $stable(dir_reg))
		else $error("direction written in address mode");

	latch_write_a: assert property ( // R05
		@(posedge CORE_CLK) disable iff (clear)
		wr_ok && ADDR == port2_pkg::LATCH_OFFSET
			|=> latch_reg == $past(WDATA))
		else $error("latch write lost");

	pull_write_a: assert property ( // R09
		@(posedge CORE_CLK) disable iff (clear)
		wr_ok && ADDR == port2_pkg::PULL_OFFSET
			|=> pull_reg == $past(WDATA))
		else $error("pull-up control write lost");

	// soft standby must not let a stray write slip through
	regs_hold_a: assert property ( // R08
		@(posedge CORE_CLK) disable iff (clear)
		SW_STANDBY |=> $stable(dir_reg) && $stable(latch_reg)
			&& $stable(pull_reg))
		else $error("registers moved in standby");

	port_read_a: assert property ( // R06
		@(posedge CORE_CLK) disable iff (RST)
		RD && ADDR == port2_pkg::LATCH_OFFSET |=> RDATA ==
			(($past(dir_eff) & $past(latch_reg)) |
			(~$past(dir_eff) & $past(lvl_reg))))
		else $error("port readback wrong");

	dir_read_a: assert property ( // R01
		@(posedge CORE_CLK) disable iff (RST)
		RD && ADDR == port2_pkg::DIR_OFFSET
			|=> RDATA == port2_pkg::DIR_READBACK)
		else $error("direction readback not all ones");

	pull_gate_a: assert property ( // R11
		@(posedge CORE_CLK) disable iff (clear)
		run && fn != port2_pkg::FN_ADDR
			|=> PULLUP_EN == ($past(pull_reg) & ~$past(dir_reg)))
		else $error("pull-up gating wrong");

	pull_addr_a: assert property ( // R12
		@(posedge CORE_CLK) disable iff (clear)
		run && fn == port2_pkg::FN_ADDR |=> PULLUP_EN == '0)
		else $error("pull-up on in address mode");

	standby_hold_a: assert property ( // R03
		@(posedge CORE_CLK) disable iff (clear)
		SW_STANDBY |=> $stable(PIN_OUT) && $stable(PIN_OE_N)
			&& $stable(PULLUP_EN))
		else $error("pins moved in standby");

	addr_out_a: assert property ( // R18
		@(posedge CORE_CLK) disable iff (clear)
		run && fn != port2_pkg::FN_GPIO |=> PIN_OUT == $past(ADDR_HI))
		else $error("address byte not driven");

	gpio_out_a: assert property ( // R17
		@(posedge CORE_CLK) disable iff (clear)
		run && fn == port2_pkg::FN_GPIO |=> PIN_OUT == $past(latch_reg)
			&& PIN_OE_N == ~$past(dir_reg))
		else $error("gpio drive wrong");

	mixed_dir_a: assert property ( // R15
		@(posedge CORE_CLK) disable iff (clear)
		run && fn == port2_pkg::FN_MIXED
			|=> PIN_OE_N == ~$past(dir_reg))
		else $error("mode 5 direction ignored");

	mixed_drive_c: cover property (@(posedge CORE_CLK) disable iff (clear)
		fn == port2_pkg::FN_MIXED && dir_reg != '0 ##1 PIN_OE_N != '1);
	pin_read_c: cover property (@(posedge CORE_CLK) disable iff (clear)
		RD && ADDR == port2_pkg::LATCH_OFFSET && dir_eff == '0);
	pull_on_c: cover property (@(posedge CORE_CLK) disable iff (clear)
		PULLUP_EN != '0);
	standby_c: cover property (@(posedge CORE_CLK) disable iff (clear)
		PIN_OE_N != '1 ##1 SW_STANDBY [*3]);
	addr_mode_c: cover property (@(posedge CORE_CLK) disable iff (clear)
		fn == port2_pkg::FN_ADDR && PIN_OE_N == '0);
endmodule
`default_nettype wire

/* dv/pin_board.sv */
`default_nettype none
module pin_board (
	// clock
	input  wire logic       clk,
	// device side
	input  wire logic [7:0] out,
	input  wire logic [7:0] oe_n,
	input  wire logic [7:0] pull,
	// board drivers
	input  wire logic [7:0] ext,
	input  wire logic [7:0] ext_en,
	// resolved levels
	output logic      [7:0] level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] flt = 8'h55;
	// floating pins wander so no stale value passes for a read
	always_ff @(posedge clk) begin
		flt <= ~flt;
	end
	// board driver wins a fight, so latch readback shows
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level[i] = ext_en[i] ? ext[i] : !oe_n[i] ? out[i] :
				pull[i] ? 1'b1 : flt[i];
		end
	end
endmodule
`default_nettype wire

/* dv/eight_bit_port_with_pullups_bench.sv */
`default_nettype none
`define CHK(nm, ex, sn) chk(nm, ex, sn)
module eight_bit_port_with_pullups_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 0, rst = 1, hws = 0, sws = 0, wr = 0, rd = 0;
	logic [2:0]  mode = 3'h6;
	logic [7:0]  ahi = 8'h00, wd = 8'h00, rdata, pout, oen, pen, lvl;
	logic [7:0]  ext = 8'h00, ext_en = 8'h00, v;
	logic [15:0] adr = 16'h0000;
	int          mismatches = 0, n_checks = 0;
	// ************************************
	// device and board
	// ************************************
	addr_port addr_port_inst (.CORE_CLK(clk), .RST(rst), .MODE(mode),
		.HW_STANDBY(hws), .SW_STANDBY(sws), .ADDR_HI(ahi), .ADDR(adr),
		.WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(lvl),
		.PIN_OUT(pout), .PIN_OE_N(oen), .PULLUP_EN(pen));
	pin_board pin_board_inst (.clk(clk), .out(pout), .oe_n(oen),
		.pull(pen), .ext(ext), .ext_en(ext_en), .level(lvl));
	initial begin
		forever #4 clk = ~clk;
	end
	// ************************************
	// bus and checking helpers
	// ************************************
	task automatic chk(string nm, logic [7:0] ex, logic [7:0] sn);
		n_checks++;
		if (sn !== ex) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, ex, sn);
		end
	endtask
	task automatic wr8(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd8(logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		adr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask
	task automatic settle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pins(string nm, logic [7:0] o, logic [7:0] e,
		logic [7:0] p);
		settle(2);
		`CHK({nm, " out"}, o, pout);
		`CHK({nm, " oe_n"}, e, oen);
		`CHK({nm, " pull"}, p, pen);
	endtask
	task automatic hw_clear();
		@(posedge clk);
		hws <= 1;
		settle(2);
		@(posedge clk);
		hws <= 0;
	endtask
	// ************************************
	// scenarios
	// ************************************
	task automatic t_reset();
		pins("rst", 8'h00, 8'hff, 8'h00);
		// all outputs, so the port read shows the latch itself
		wr8(16'hffc1, 8'hff);
		rd8(16'hffc3, v);
		`CHK("latch", 8'h00, v);
		rd8(16'hffd8, v);
		`CHK("pullctl", 8'h00, v);
		rd8(16'hffc1, v);
		`CHK("dir read", 8'hff, v);
		rd8(16'hffc5, v);
		`CHK("unmapped", 8'h00, v);
	endtask
	task automatic t_gpio();
		wr8(16'hffc1, 8'h0f);
		wr8(16'hffc3, 8'ha5);
		pins("gpio", 8'ha5, 8'hf0, 8'h00);
		ext <= 8'h3c;
		ext_en <= 8'hff;
		settle(6);
		rd8(16'hffc3, v);
		`CHK("port rd", 8'h35, v);
		wr8(16'hffd8, 8'hff);
		ext_en <= 8'h00;
		pins("gpio", 8'ha5, 8'hf0, 8'hf0);
		settle(5);
		rd8(16'hffc3, v);
		`CHK("pulled rd", 8'hf5, v);
	endtask
	task automatic t_swstby();
		@(posedge clk);
		sws <= 1;
		wr8(16'hffc3, 8'h00);
		wr8(16'hffc1, 8'h00);
		pins("sws", 8'ha5, 8'hf0, 8'hf0);
		@(posedge clk);
		sws <= 0;
		rd8(16'hffc3, v);
		`CHK("sws latch", 8'hf5, v);
		rd8(16'hffd8, v);
		`CHK("sws pullctl", 8'hff, v);
		pins("sws end", 8'ha5, 8'hf0, 8'hf0);
	endtask
	task automatic t_hwstby();
		hw_clear();
		pins("hws", 8'h00, 8'hff, 8'h00);
		rd8(16'hffd8, v);
		`CHK("hws pullctl", 8'h00, v);
		ext_en <= 8'hff;
		ext <= 8'h00;
		settle(5);
		// outputs again, so the read shows the cleared latch
		wr8(16'hffc1, 8'hff);
		rd8(16'hffc3, v);
		`CHK("hws latch", 8'h00, v);
		wr8(16'hffc1, 8'h00);
	endtask
	task automatic t_mode5();
		@(posedge clk);
		mode <= 3'h5;
		ahi <= 8'hc3;
		wr8(16'hffd8, 8'hff);
		pins("m5 in", 8'hc3, 8'hff, 8'hff);
		wr8(16'hffc1, 8'h01);
		pins("m5 adr", 8'hc3, 8'hfe, 8'hfe);
		@(posedge clk);
		ahi <= 8'h81;
		pins("m5 ahi", 8'h81, 8'hfe, 8'hfe);
	endtask
	task automatic t_mode13(logic [2:0] m);
		hw_clear();
		mode <= m;
		ahi <= 8'h5a;
		wr8(16'hffc1, 8'hff);
		wr8(16'hffd8, 8'hff);
		pins("m13", 8'h5a, 8'h00, 8'h00);
		rd8(16'hffc1, v);
		`CHK("m13 dir", 8'hff, v);
		@(posedge clk);
		mode <= 3'h6;
		pins("m13 left", 8'h00, 8'hff, 8'hff);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ************************************
	// main sequence and watchdog
	// ************************************
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		t_reset();
		t_gpio();
		t_swstby();
		t_hwstby();
		t_mode5();
		t_mode13(3'h1);
		t_mode13(3'h3);
		end_sim();
	end
	// the run needs well under a thousand cycles
	initial begin
		#20000;
		mismatches++;
		end_sim();
	end
endmodule
`default_nettype wire
